// ### hdl/dual_timer_consts.vh
// Constants for the dual 16-bit timer: register offsets, field positions,
// reset values and combination mode codes.
// Assumes an APB master with 32-bit data and byte addresses on paddr[7:0].
//
// Operation
// - General register A pairs with buffer C, B pairs with buffer D.
// - Buffered compare match toggles pin and loads buffer into general register together.
// - Buffered capture loads counter into general register, old value into buffer.
// - Complementary PWM moves buffer D0 to B0 on period match or underflow.
// - Buffer at or above period register transfers only on channel-1 underflow.
// - Buffer equal to zero transfers only on channel-0 period match.
// - Master disable bit set hands pins to the port level registers.
// - Low level on armed wake-up pin sets the master disable bit.
// - Level-select bits invert outputs in combined modes, polarity bits in PWM.
// - Interrupt request when a flag and its enable are both one.
// - Compare match fires at the counter clock after equality is reached.
// - Capture sets the match flag and copies the counter in one cycle.
// - Overflow flag sets when the counter wraps past its maximum.
// - A flag clears only by writing zero after reading it as one.
// - Counter clear beats a simultaneous counter write.
// - Counter write beats a simultaneous increment.
// - General register write wins and suppresses a simultaneous compare match.
// - Counter write during wrap stores the value, overflow flag still sets.
// - A read racing a capture returns the value from before capture.
// - Capture clear beats increment; general register gets the pre-clear count.
// - Capture beats a simultaneous general register write.
// - Initial-level write beats a compare match; that match's pin change is lost.
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH

// Per-channel block: channel index in bit 5, register index in bits 4:2
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_IRQ_ENABLE 3'h2
`define REG_COUNT 3'h3
`define REG_GENERAL_A 3'h4
`define REG_GENERAL_B 3'h5
`define REG_BUFFER_A 3'h6
`define REG_BUFFER_B 3'h7

// Common block, selected by bit 6
`define REG_FUNCTION_CTRL 3'h0
`define REG_OUTPUT_DISABLE 3'h1
`define REG_INITIAL_LEVEL 3'h2
`define REG_PWM_POLARITY 3'h3
`define ADDR_COMMON_BIT 6
`define ADDR_CHANNEL_BIT 5
`define ADDR_TOP 8'h80

// Channel control fields
`define CTRL_PRESCALE_LSB 0
`define CTRL_START 2
`define CTRL_CLEAR_ON_B 3
`define CTRL_BUFFER_A 4
`define CTRL_BUFFER_B 5
`define CTRL_CAPTURE_A 6
`define CTRL_CAPTURE_B 7
`define CTRL_PWM_MODE 8
`define CTRL_WIDTH 9

// Status and enable fields
`define FLAG_MATCH_A 0
`define FLAG_MATCH_B 1
`define FLAG_WRAP 2
`define FLAG_UNDER 3

// Function control fields
`define FUNC_MODE_LO 0
`define FUNC_MODE_HI 1
`define FUNC_LEVEL_LO 2
`define FUNC_LEVEL_HI 3

// Output disable fields
`define DIS_MASTER 0
`define DIS_WAKE_ARM 1
`define DIS_PORT_LSB 4

// Combination modes
`define MODE_NORMAL 2'h0
`define MODE_RESET_SYNC 2'h1
`define MODE_COMP_PERIOD 2'h2
`define MODE_COMP_UNDER 2'h3

`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define RESET_INITIAL_LEVEL 4'h0

`endif

// ### hdl/dual_timer_buffer_output_ctrl.v
// Two-channel 16-bit timer with buffered general registers, output
// disable, polarity control and flag handling, as an APB slave.
// Assumes synchronous pin inputs and one APB master on clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_consts.vh"

module dual_timer_buffer_output_ctrl #(
    parameter CHANNELS = 2
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] timerPinIn,
    output reg [3:0] timerPinOut,
    output reg [3:0] timerPinOe,
    input wire wakeupTriggerPin,
    output reg [1:0] irq
);

    // Reset pin levels as a vector, so each channel picks its own bits
    localparam [3:0] RESET_LEVEL = `RESET_INITIAL_LEVEL;

    // Channel-block decode for channel ch, shared by writes and status reads
    function chanHit;
        input [7:0] addr;
        input integer ch;
        begin
            chanHit = ~addr[`ADDR_COMMON_BIT] & (addr[`ADDR_CHANNEL_BIT] == (ch == 1));
        end
    endfunction

    // APB decode; write lands in the access cycle, read data is latched in setup
    wire setupPhase = psel & ~penable;
    wire apbWrite = psel & penable & pready & pwrite;
    wire isCommon = paddr[`ADDR_COMMON_BIT];
    wire [2:0] regSel = paddr[4:2];
    wire mapped = (paddr < `ADDR_TOP) && (paddr[1:0] == 2'h0)
        && !(isCommon && paddr[4]) && !(isCommon && paddr[5]);
    wire wrCommon = apbWrite & mapped & isCommon;

    // Common registers
    reg [3:0] functionCtrl;
    reg [7:0] outputDisable;
    reg [3:0] initialLevel;
    reg [3:0] pwmPolarity;
    reg [2:0] prescaleCount;

    wire [1:0] combMode = {functionCtrl[`FUNC_MODE_HI], functionCtrl[`FUNC_MODE_LO]};
    wire compMode = combMode[1];
    wire initialWrite = wrCommon && (regSel == `REG_INITIAL_LEVEL);
    wire wakeTrip = outputDisable[`DIS_WAKE_ARM] & ~wakeupTriggerPin;

    // Values gathered from the channels
    wire [31:0] ctrlAll;
    wire [7:0] statusAll;
    wire [7:0] enableAll;
    wire [31:0] countAll;
    wire [31:0] genAAll;
    wire [31:0] genBAll;
    wire [31:0] bufAAll;
    wire [31:0] bufBAll;
    wire [3:0] levelAll;
    wire [3:0] captureAll;
    wire [1:0] periodMatch;
    wire [1:0] underflowEv;
    wire [1:0] pwmAll;
    wire [1:0] irqAll;

    // Free-running prescaler shared by both channels
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prescaleCount <= 3'h0;
        end else begin
            prescaleCount <= prescaleCount + 3'h1;
        end
    end

    // Common register writes; wake-up trip sets master disable over a write
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            functionCtrl <= 4'h0;
            outputDisable <= 8'h00;
            initialLevel <= `RESET_INITIAL_LEVEL;
            pwmPolarity <= 4'h0;
        end else begin
            if (wrCommon && regSel == `REG_FUNCTION_CTRL) begin
                functionCtrl <= pwdata[3:0];
            end
            if (wrCommon && regSel == `REG_INITIAL_LEVEL) begin
                initialLevel <= pwdata[3:0];
            end
            if (wrCommon && regSel == `REG_PWM_POLARITY) begin
                pwmPolarity <= pwdata[3:0];
            end
            if (wrCommon && regSel == `REG_OUTPUT_DISABLE) begin
                outputDisable <= pwdata[7:0];
            end
            if (wakeTrip) begin
                outputDisable[`DIS_MASTER] <= 1'b1;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gen_ch
            reg [`CTRL_WIDTH-1:0] ctrl;
            reg [3:0] status;
            reg [3:0] irqEnable;
            reg [3:0] readArmed;
            reg [15:0] timerCount;
            reg [15:0] generalRegA;
            reg [15:0] generalRegB;
            reg [15:0] bufferRegA;
            reg [15:0] bufferRegB;
            reg levelA;
            reg levelB;
            reg [1:0] pinPrev;

            wire wrCh = apbWrite & mapped & chanHit(paddr, i);
            wire rdStatus = setupPhase & ~pwrite & mapped & chanHit(paddr, i)
                & (regSel == `REG_STATUS);
            wire wrCount = wrCh && regSel == `REG_COUNT;
            wire wrGenA = wrCh && regSel == `REG_GENERAL_A;
            wire wrGenB = wrCh && regSel == `REG_GENERAL_B;
            wire capA = ctrl[`CTRL_CAPTURE_A];
            wire capB = ctrl[`CTRL_CAPTURE_B];
            wire [1:0] psel2 = ctrl[`CTRL_PRESCALE_LSB+1:`CTRL_PRESCALE_LSB];
            wire hit = (psel2 == 2'h0) ? 1'b1 :
                (psel2 == 2'h1) ? (prescaleCount[0] == 1'b1) :
                (psel2 == 2'h2) ? (prescaleCount[1:0] == 2'h3) :
                (prescaleCount == 3'h7);
            wire tick = ctrl[`CTRL_START] & hit;
            wire countDown = (i == 1) && compMode;
            // Match only on the counter clock while equal; a write suppresses it
            wire matchA = tick & (timerCount == generalRegA) & ~capA & ~wrGenA;
            wire matchB = tick & (timerCount == generalRegB) & ~capB & ~wrGenB;
            wire capEvA = capA & timerPinIn[2*i] & ~pinPrev[0];
            wire capEvB = capB & timerPinIn[2*i+1] & ~pinPrev[1];
            wire clearEv = ctrl[`CTRL_CLEAR_ON_B] & (matchB | capEvB);
            wire wrapEv = tick & ~countDown & (timerCount == `COUNT_MAX);
            wire underEv = tick & countDown & (timerCount == `COUNT_ZERO);
            // Complementary transfer of buffer B into general B on channel 0
            wire bufZero = (bufferRegB == `COUNT_ZERO);
            wire bufHigh = (bufferRegB >= generalRegA);
            wire compXfer = (i == 0) && compMode && ctrl[`CTRL_BUFFER_B] && (
                bufZero ? periodMatch[0] :
                bufHigh ? underflowEv[1] :
                (combMode == `MODE_COMP_UNDER) ? underflowEv[1] : periodMatch[0]);
            wire normXferB = ~compMode & ctrl[`CTRL_BUFFER_B] & matchB;
            wire [3:0] flagSet = {underEv, wrapEv, matchB | capEvB, matchA | capEvA};
            wire [3:0] flagClr = (wrCh && regSel == `REG_STATUS) ?
                (~pwdata[3:0] & readArmed) : 4'h0;

            assign ctrlAll[16*i +: 16] = {{(16-`CTRL_WIDTH){1'b0}}, ctrl};
            assign statusAll[4*i +: 4] = status;
            assign enableAll[4*i +: 4] = irqEnable;
            assign countAll[16*i +: 16] = timerCount;
            assign genAAll[16*i +: 16] = generalRegA;
            assign genBAll[16*i +: 16] = generalRegB;
            assign bufAAll[16*i +: 16] = bufferRegA;
            assign bufBAll[16*i +: 16] = bufferRegB;
            assign levelAll[2*i +: 2] = {levelB, levelA};
            assign captureAll[2*i +: 2] = {capB, capA};
            assign periodMatch[i] = matchA;
            assign underflowEv[i] = underEv;
            assign pwmAll[i] = ctrl[`CTRL_PWM_MODE];
            assign irqAll[i] = |(status & irqEnable);

            // Control, enables and edge history
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    ctrl <= {`CTRL_WIDTH{1'b0}};
                    irqEnable <= 4'h0;
                    pinPrev <= 2'h0;
                end else begin
                    pinPrev <= timerPinIn[2*i +: 2];
                    if (wrCh && regSel == `REG_CTRL) begin
                        ctrl <= pwdata[`CTRL_WIDTH-1:0];
                    end
                    if (wrCh && regSel == `REG_IRQ_ENABLE) begin
                        irqEnable <= pwdata[3:0];
                    end
                end
            end

            // Flags: set beats clear; clear needs a prior read as one
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    status <= 4'h0;
                    readArmed <= 4'h0;
                end else begin
                    status <= flagSet | (status & ~flagClr);
                    if (rdStatus) begin
                        readArmed <= status;
                    end else if (wrCh && regSel == `REG_STATUS) begin
                        readArmed <= 4'h0;
                    end
                end
            end

            // Counter: clear, then write, then count
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    timerCount <= `COUNT_ZERO;
                end else if (clearEv) begin
                    timerCount <= `COUNT_ZERO;
                end else if (wrCount) begin
                    timerCount <= pwdata[15:0];
                end else if (tick) begin
                    timerCount <= countDown ? timerCount - 16'h0001 : timerCount + 16'h0001;
                end
            end

            // General and buffer registers; capture beats a CPU write
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    generalRegA <= `COUNT_MAX;
                    generalRegB <= `COUNT_MAX;
                    bufferRegA <= `COUNT_MAX;
                    bufferRegB <= `COUNT_MAX;
                end else begin
                    if (capEvA) begin
                        generalRegA <= timerCount;
                        if (ctrl[`CTRL_BUFFER_A]) begin
                            bufferRegA <= generalRegA;
                        end
                    end else if (wrGenA) begin
                        generalRegA <= pwdata[15:0];
                    end else if (matchA && ctrl[`CTRL_BUFFER_A]) begin
                        generalRegA <= bufferRegA;
                    end
                    if (capEvB) begin
                        generalRegB <= timerCount;
                        if (ctrl[`CTRL_BUFFER_B]) begin
                            bufferRegB <= generalRegB;
                        end
                    end else if (wrGenB) begin
                        generalRegB <= pwdata[15:0];
                    end else if (compXfer || normXferB) begin
                        generalRegB <= bufferRegB;
                    end
                    if (wrCh && regSel == `REG_BUFFER_A && !(capEvA && ctrl[`CTRL_BUFFER_A])) begin
                        bufferRegA <= pwdata[15:0];
                    end
                    if (wrCh && regSel == `REG_BUFFER_B && !(capEvB && ctrl[`CTRL_BUFFER_B])) begin
                        bufferRegB <= pwdata[15:0];
                    end
                end
            end

            // Pin levels toggle on match; an initial-level write overrides
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    levelA <= RESET_LEVEL[2*i];
                    levelB <= RESET_LEVEL[2*i+1];
                end else if (initialWrite) begin
                    levelA <= pwdata[2*i];
                    levelB <= pwdata[2*i+1];
                end else begin
                    if (matchA) begin
                        levelA <= ~levelA;
                    end
                    if (matchB) begin
                        levelB <= ~levelB;
                    end
                end
            end

        end
    endgenerate

    // Interrupt requests, one register for both channels
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 2'h0;
        end else begin
            irq <= irqAll;
        end
    end

    // Output inversion per pin: level select in combined modes, polarity in PWM
    reg [3:0] invert;
    integer p;
    always @* begin
        invert = 4'h0;
        for (p = 0; p < 4; p = p + 1) begin
            if (pwmAll[p/2]) begin
                invert[p] = pwmPolarity[p];
            end else if (combMode != `MODE_NORMAL) begin
                invert[p] = p[0] ? functionCtrl[`FUNC_LEVEL_HI]
                    : functionCtrl[`FUNC_LEVEL_LO];
            end
        end
    end

    // Pin drivers; disabled pins show the port level bits
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timerPinOut <= 4'h0;
            timerPinOe <= 4'hF;
        end else begin
            if (outputDisable[`DIS_MASTER]) begin
                timerPinOut <= outputDisable[`DIS_PORT_LSB +: 4];
            end else begin
                timerPinOut <= levelAll ^ invert;
            end
            timerPinOe <= captureAll;
        end
    end

    // Read data, latched in the setup cycle
    reg [31:0] readValue;
    always @* begin
        readValue = 32'h0000_0000;
        if (isCommon) begin
            case (regSel)
                `REG_FUNCTION_CTRL: readValue = {28'h000_0000, functionCtrl};
                `REG_OUTPUT_DISABLE: readValue = {24'h00_0000, outputDisable};
                `REG_INITIAL_LEVEL: readValue = {28'h000_0000, initialLevel};
                `REG_PWM_POLARITY: readValue = {28'h000_0000, pwmPolarity};
                default: readValue = 32'h0000_0000;
            endcase
        end else if (paddr[`ADDR_CHANNEL_BIT]) begin
            case (regSel)
                `REG_CTRL: readValue = {16'h0000, ctrlAll[31:16]};
                `REG_STATUS: readValue = {28'h000_0000, statusAll[7:4]};
                `REG_IRQ_ENABLE: readValue = {28'h000_0000, enableAll[7:4]};
                `REG_COUNT: readValue = {16'h0000, countAll[31:16]};
                `REG_GENERAL_A: readValue = {16'h0000, genAAll[31:16]};
                `REG_GENERAL_B: readValue = {16'h0000, genBAll[31:16]};
                `REG_BUFFER_A: readValue = {16'h0000, bufAAll[31:16]};
                default: readValue = {16'h0000, bufBAll[31:16]};
            endcase
        end else begin
            case (regSel)
                `REG_CTRL: readValue = {16'h0000, ctrlAll[15:0]};
                `REG_STATUS: readValue = {28'h000_0000, statusAll[3:0]};
                `REG_IRQ_ENABLE: readValue = {28'h000_0000, enableAll[3:0]};
                `REG_COUNT: readValue = {16'h0000, countAll[15:0]};
                `REG_GENERAL_A: readValue = {16'h0000, genAAll[15:0]};
                `REG_GENERAL_B: readValue = {16'h0000, genBAll[15:0]};
                `REG_BUFFER_A: readValue = {16'h0000, bufAAll[15:0]};
                default: readValue = {16'h0000, bufBAll[15:0]};
            endcase
        end
    end

    // APB answer: ready one cycle after setup, error on unmapped address
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~mapped;
            if (setupPhase && !pwrite) begin
                prdata <= mapped ? readValue : 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// ### sim/dual_timer_buffer_output_ctrl_asserts.sv
// Checker for the dual timer APB slave ports.
// Assumes it is bound to the top module; one clock, active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_buffer_output_ctrl_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Unmapped, unaligned or past the common block
    wire badAddr = paddr[7] || (paddr[1:0] != 2'h0) || (paddr[6] && paddr[5:4] != 2'h0);
    // Transfer phases
    sequence setupCyc;
        psel && !penable;
    endsequence
    sequence rdSetup;
        psel && !penable && !pwrite;
    endsequence
    chk_ready_after_setup: assert property (setupCyc |=> pready) // [APB]
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready) // [APB]
        else $error("pready held too long");
    chk_no_ready_setup: assert property (setupCyc |-> !pready) // [APB]
        else $error("pready in setup cycle");
    chk_err_with_ready: assert property (pslverr |-> pready) // [APB]
        else $error("pslverr without pready");
    chk_bad_addr_err: assert property (setupCyc ##0 badAddr |=> pslverr) // [APB]
        else $error("no error on unmapped address");
    chk_good_addr_ok: assert property (setupCyc ##0 !badAddr |=> !pslverr) // [APB]
        else $error("error on mapped address");
    chk_bad_read_zero: assert property (rdSetup ##0 badAddr |=> prdata == 32'h0000_0000) // [APB]
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (prdata[31:16] == 16'h0000) // [APB]
        else $error("upper read bits set");
    chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
endmodule
bind dual_timer_buffer_output_ctrl dual_timer_buffer_output_ctrl_asserts chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### sim/timer_pin_partner.sv
// Signal sources and loads on the timer pins and the wake-up line.
// Assumes active-low output enables; a released pin shows the source.
`timescale 1ns/100ps
`default_nettype none
module timer_pin_partner (
    input wire logic [3:0] timerPinOut,
    input wire logic [3:0] timerPinOe,
    input wire logic [3:0] srcLevel,
    input wire logic wakeLow,
    output logic [3:0] timerPinIn,
    output logic wakeupTriggerPin
);
    // Wire level: device drive where enabled, else the source
    assign timerPinIn = (timerPinOut & ~timerPinOe) | (srcLevel & timerPinOe);
    // Wake-up line pulled up unless the source pulls it low
    assign wakeupTriggerPin = !wakeLow;
endmodule
`default_nettype wire

// ### sim/dual_timer_buffer_output_ctrl_bench.sv
// Self-checking bench for the dual timer: APB tasks and pin checks.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_buffer_output_ctrl_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wakeLow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, wakeupTriggerPin, rerr;
    logic [3:0] timerPinIn, timerPinOut, timerPinOe;
    logic [3:0] srcLevel = 4'h0;
    logic [1:0] irq;
    logic [7:0] bad [3] = '{8'h80, 8'h41, 8'h50};
    int failures = 0;
    int n_tests = 0;
    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;
    dual_timer_buffer_output_ctrl dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerPinIn(timerPinIn),
        .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
        .wakeupTriggerPin(wakeupTriggerPin), .irq(irq));
    timer_pin_partner pins (.timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
        .srcLevel(srcLevel), .wakeLow(wakeLow), .timerPinIn(timerPinIn),
        .wakeupTriggerPin(wakeupTriggerPin));
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rdata = prdata;
        rerr = pslverr;
        if (k >= 40) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Register write, register read with compare, idle cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        #200_000;
        failures++;
        end_sim();
    end
    // Test sequence
    initial begin
        tick(10);
        rst <= 1'b0;
        rd(8'h10, 32'h0000_FFFF, "genA0");
        rd(8'h18, 32'h0000_FFFF, "bufA0");
        rd(8'h3C, 32'h0000_FFFF, "bufB1");
        rd(8'h0C, 32'h0000_0000, "count0");
        chk("pinsReset", 32'h0000_0000, timerPinOut);
        foreach (bad[i]) begin
            rd(bad[i], 32'h0000_0000, "badRead");
            chk("badErr", 32'h0000_0001, rerr);
        end
        $display("test reset and map done");
        wr(8'h0C, 32'h0000_FFFE);
        wr(8'h00, 32'h0000_0004);
        tick(6);
        wr(8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_0007, "wrapFlags");
        wr(8'h04, 32'h0000_0003);
        rd(8'h04, 32'h0000_0003, "wrapCleared");
        wr(8'h08, 32'h0000_0001);
        tick(2);
        chk("irqOn", 32'h0000_0001, irq);
        wr(8'h04, 32'h0000_0000);
        tick(2);
        chk("irqOff", 32'h0000_0000, irq);
        $display("test flags done");
        wr(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0010);
        wr(8'h18, 32'h0000_0020);
        wr(8'h00, 32'h0000_0014);
        tick(20);
        wr(8'h00, 32'h0000_0000);
        rd(8'h10, 32'h0000_0020, "bufToGen");
        // A0 and B0 toggled at the FFFF match, A0 again at 0x10
        chk("toggleA0", 32'h0000_0002, timerPinOut);
        rd(8'h04, 32'h0000_0001, "matchFlag");
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0054);
        tick(5);
        chk("oeCapture", 32'h0000_0001, timerPinOe);
        srcLevel <= 4'h1;
        tick(3);
        wr(8'h00, 32'h0000_0000);
        srcLevel <= 4'h0;
        rd(8'h18, 32'h0000_0020, "genToBuf");
        rd(8'h04, 32'h0000_0001, "capFlag");
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("capValue", 32'h0000_001C, rdata);
        $display("test buffers done");
        wr(8'h44, 32'h0000_00A1);
        tick(2);
        chk("disabledPins", 32'h0000_000A, timerPinOut);
        wr(8'h44, 32'h0000_0052);
        wakeLow <= 1'b1;
        tick(3);
        wakeLow <= 1'b0;
        rd(8'h44, 32'h0000_0053, "wakeTrip");
        chk("wakePins", 32'h0000_0005, timerPinOut);
        wr(8'h44, 32'h0000_0000);
        $display("test disable done");
        wr(8'h48, 32'h0000_0005);
        tick(2);
        chk("initLevel", 32'h0000_0005, timerPinOut);
        wr(8'h40, 32'h0000_0005);
        tick(2);
        chk("invSync", 32'h0000_0000, timerPinOut);
        wr(8'h40, 32'h0000_0000);
        wr(8'h40, 32'h0000_0006);
        tick(2);
        chk("invComp", 32'h0000_0000, timerPinOut);
        wr(8'h40, 32'h0000_0000);
        tick(2);
        chk("invOff", 32'h0000_0005, timerPinOut);
        $display("test levels done");
        end_sim();
    end
endmodule
`default_nettype wire
